// File: shared/sdb_pkg.sv
// Package with register map, field layout, reset values and types for the serial data buffer and baud generator
package sdb_pkg;
    // Register offsets on the plain register port
    localparam logic [7:0] SDB_DATA_OFS = 8'h18;
    localparam logic [7:0] SDB_BAUD_OFS = 8'h19;
    localparam logic [7:0] SDB_STAT_OFS = 8'h1a;
    // Baud select field positions
    localparam int SDB_RATE_LSB = 0;
    localparam int SDB_PRE_LSB = 4;
    localparam logic [7:0] SDB_BAUD_RST = 8'h00;
    // Status field positions
    localparam int SDB_STAT_TXE = 7;
    localparam int SDB_STAT_RXF = 5;
    // Fixed divide by 64 per bit, sampling tick at 16x bit rate
    localparam logic [5:0] SDB_BIT_DIV = 6'h3f;
    localparam logic [1:0] SDB_TICK_PER_BIT = 2'h3;
    localparam int SDB_FIFO_DEPTH = 8;

    typedef struct packed {
        logic [1:0] pre;
        logic [2:0] rate;
    } sdb_baud_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sdb_bus_t;

    typedef enum logic [2:0] {
        SDB_ST_IDLE = 3'h1,
        SDB_ST_ARM = 3'h2,
        SDB_ST_HOLD = 3'h4
    } sdb_arm_t;
endpackage

// File: src/sdb_fifo.sv
// Synchronous FIFO carrying transmit bytes toward the shift register
`timescale 1ns/1ps
module sdb_fifo
    import sdb_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = SDB_FIFO_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wptr_r;
    logic [AW:0] rptr_r;
    wire logic push = in_valid_i && in_ready_o;
    wire logic pop = out_valid_o && out_ready_i;

    // Full when pointers differ only in the wrap bit
    assign in_ready_o = !((wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]));
    assign out_valid_o = (wptr_r != rptr_r);
    assign out_data_o = mem[rptr_r[AW-1:0]];

    // Storage has no reset, only the pointers do
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            wptr_r <= wptr_r + (AW+1)'(push);
            rptr_r <= rptr_r + (AW+1)'(pop);
        end
    end
endmodule

// File: src/sdb_core.sv
// Serial data buffer with flag handshakes and two-stage baud rate generator
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Reads give received byte, writes queue transmit
// - Reset leaves receive buffer contents alone
// - One baud setting drives receiver and transmitter
// - Prescale code picks divisor 1,3,4,13
// - Rate code n picks divisor two^n
// - Bit rate is source over 64*PD*BD
// - Source is bus clock or crystal reference
// - Reset clears prescale and rate codes
// - Status read then data write clears tx-empty
// - Status read then data read clears rx-full
module sdb_core
    import sdb_pkg::*;
#(
    parameter int FIFO_DEPTH = SDB_FIFO_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic baud_clock_source_sel_i,
    input wire logic crystal_ref_clock_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output logic [7:0] tx_data_o,
    output logic tx_accept_o,
    output logic bit_tick_o,
    output logic sample_tick_o
);
    // Register map on the plain port
    //   0x18 data buffer: a read gives the last received byte, a write
    //        queues a byte for transmission; the two directions are
    //        separate storage, so a read never returns what was written
    //   0x19 baud select: bits 5:4 prescale code, bits 2:0 rate code
    //   0x1a status: bit 7 transmit empty, bit 5 receive full
    // Every other address reads as zero and ignores writes.
    // Read data stands for exactly one cycle after the read strobe and is
    // zero at all other times, so several slaves can share an OR-ed bus.
    // Software must treat the data buffer as read-only or write-only per
    // access: a read consumes a character and a write queues one.

    // Bus request and configuration
    sdb_bus_t bus;
    sdb_baud_t baud_r;
    // Data path, handshake and divider counter state
    logic [7:0] rx_buf_r;
    logic [7:0] reg_rdata_r;
    logic tx_empty_flag_r;
    logic rx_full_flag_r;
    sdb_arm_t tx_arm_r;
    sdb_arm_t rx_arm_r;
    logic [3:0] pre_cnt_r;
    logic [6:0] rate_cnt_r;
    logic [5:0] bit_cnt_r;
    // Divider chain state
    logic xref_q_r;
    logic bit_tick_r;
    logic sample_tick_r;

    // Prescaler divisor minus one, per prescale code
    function automatic logic [3:0] pre_last(input logic [1:0] code);
        case (code)
            2'h0: pre_last = 4'h0;
            2'h1: pre_last = 4'h2;
            2'h2: pre_last = 4'h3;
            2'h3: pre_last = 4'hc;
            default: pre_last = 4'h0;
        endcase
    endfunction

    // Baud divisor minus one, two to the power of the code
    function automatic logic [6:0] rate_last(input logic [2:0] code);
        rate_last = 7'((8'h01 << code) - 8'h01);
    endfunction

    assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    // Address decode
    wire logic hit_data = (bus.addr == SDB_DATA_OFS);
    wire logic hit_baud = (bus.addr == SDB_BAUD_OFS);
    wire logic hit_stat = (bus.addr == SDB_STAT_OFS);
    wire logic data_wr = bus.wr && hit_data;
    wire logic data_rd = bus.rd && hit_data;
    wire logic stat_rd = bus.rd && hit_stat;
    wire logic baud_wr = bus.wr && hit_baud;

    // Transmit path: bytes written to the buffer go into the FIFO.
    // A write while the FIFO is full is dropped; software is expected to
    // watch the transmit-empty flag or the accept output before writing.
    // The FIFO lets software queue several bytes while the shifter is busy,
    // at the cost of the flag meaning "room and nothing waiting".
    wire logic fifo_in_ready;
    wire logic tx_push = data_wr && fifo_in_ready;
    assign tx_accept_o = fifo_in_ready;

    sdb_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(tx_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(bus.wdata),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o(tx_data_o)
    );

    // Status word and read mux
    wire logic [7:0] stat_word = 8'((tx_empty_flag_r << SDB_STAT_TXE) | (rx_full_flag_r << SDB_STAT_RXF));
    wire logic [7:0] baud_word = 8'((baud_r.pre << SDB_PRE_LSB) | (baud_r.rate << SDB_RATE_LSB));
    // Each register selected by its own hit, then gated by the strobe,
    // so idle cycles and unmapped addresses read zero
    wire logic [7:0] rd_sel_data = hit_data ? rx_buf_r : 8'h00;
    wire logic [7:0] rd_sel_baud = hit_baud ? baud_word : 8'h00;
    wire logic [7:0] rd_sel_stat = hit_stat ? stat_word : 8'h00;
    wire logic [7:0] rd_sel_any = rd_sel_data | rd_sel_baud | rd_sel_stat;
    wire logic [7:0] rdata_nxt = bus.rd ? rd_sel_any : 8'h00;
    assign reg_rdata_o = reg_rdata_r;

    // Read data stands one cycle after the strobe
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_r <= 8'h00;
        end else begin
            reg_rdata_r <= rdata_nxt;
        end
    end

    // Receive buffer has no reset so its content survives one.
    // Until the first byte arrives a read of it returns an undefined value,
    // which software must not rely on.
    always_ff @(posedge core_clk_i) begin
        if (rx_valid_i) begin
            rx_buf_r <= rx_data_i;
        end
    end

    // Written baud setting, unpacked through the field positions
    wire sdb_baud_t baud_nxt = '{pre: bus.wdata[SDB_PRE_LSB +: 2], rate: bus.wdata[SDB_RATE_LSB +: 3]};

    // Baud select register: one setting for both directions; the reset
    // value goes through the same field positions as a written one
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            baud_r <= '{pre: SDB_BAUD_RST[SDB_PRE_LSB +: 2], rate: SDB_BAUD_RST[SDB_RATE_LSB +: 3]};
        end else if (baud_wr) begin
            baud_r <= baud_nxt;
        end
    end

    // Clearing handshakes for both flags. A status read with the flag set
    // arms the clear and the matching data access then performs it. A later
    // status read while the flag is clear disarms, so a stale arm cannot
    // clear a flag that was set afterwards. Any matching data access uses
    // up the arm, so one status read never clears two characters.
    // Software latency between the two accesses is harmless: the arm waits.
    wire logic tx_room = fifo_in_ready;
    wire logic tx_set = tx_room; // Set term follows room in the transmit FIFO
    wire logic tx_clear = data_wr && (tx_arm_r == SDB_ST_ARM);
    wire logic rx_clear = data_rd && (rx_arm_r == SDB_ST_ARM);

    function automatic sdb_arm_t arm_next(input sdb_arm_t cur, input logic flag, input logic srd,
                                          input logic done);
        case (cur)
            SDB_ST_IDLE: arm_next = (srd && flag) ? SDB_ST_ARM : SDB_ST_IDLE;
            SDB_ST_ARM: arm_next = done ? SDB_ST_IDLE : (srd && !flag) ? SDB_ST_IDLE : SDB_ST_ARM;
            SDB_ST_HOLD: arm_next = SDB_ST_IDLE;
            default: arm_next = SDB_ST_IDLE;
        endcase
    endfunction

    // Handshake state for both flags
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_arm_r <= SDB_ST_IDLE;
            rx_arm_r <= SDB_ST_IDLE;
        end else begin
            tx_arm_r <= arm_next(tx_arm_r, tx_empty_flag_r, stat_rd, data_wr);
            rx_arm_r <= arm_next(rx_arm_r, rx_full_flag_r, stat_rd, data_rd);
        end
    end

    // Transmit-empty flag: set on reset; cleared by the sequence (clear wins
    // over set), then set again once the FIFO has room and no byte is waiting
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_empty_flag_r <= 1'b1;
        end else if (tx_clear) begin
            tx_empty_flag_r <= 1'b0;
        end else if (tx_set && !tx_empty_flag_r && tx_valid_o == 1'b0) begin
            tx_empty_flag_r <= 1'b1;
        end
    end

    // Receive-full flag: new byte wins over the clear
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_full_flag_r <= 1'b0;
        end else if (rx_valid_i) begin
            rx_full_flag_r <= 1'b1;
        end else if (rx_clear) begin
            rx_full_flag_r <= 1'b0;
        end
    end

    // Divider chain overview
    //   source enable -> prescaler (1, 3, 4 or 13)
    //                 -> rate stage (1 to 128, powers of two)
    //                 -> bit phase (fixed 64 per bit)
    // Each stage counts only when the stage before it wraps, so the whole
    // chain advances on core clock edges and no derived clock is made.
    // Receiver and transmitter both take their timing from this one chain;
    // there is deliberately no second divider for either direction.
    // The sample tick falls on every fourth rate wrap, sixteen per bit,
    // and the bit tick on the last of the 64 rate wraps of a bit.

    // Source select: the crystal reference is sampled as a level and each
    // rising edge gives a one-cycle enable. Everything stays in the core
    // clock domain; the limitation is that the reference must run below
    // half the core clock, or edges are lost.
    wire logic xref_rise = crystal_ref_clock_i && !xref_q_r;
    wire logic src_en = baud_clock_source_sel_i ? xref_rise : 1'b1;

    // Last count of each stage, decoded from the shared setting
    wire logic [3:0] pre_end = pre_last(baud_r.pre);
    wire logic [6:0] rate_end = rate_last(baud_r.rate);

    // Greater-or-equal rather than equal: when software lowers a divisor
    // mid-count the stage wraps at once instead of running round its range
    wire logic pre_wrap = src_en && (pre_cnt_r >= pre_end);
    wire logic rate_wrap = pre_wrap && (rate_cnt_r >= rate_end);
    wire logic bit_wrap = rate_wrap && (bit_cnt_r == SDB_BIT_DIV);
    wire logic sample_hit = rate_wrap && (bit_cnt_r[1:0] == SDB_TICK_PER_BIT);

    // Next values of the three stages
    wire logic [3:0] pre_cnt_nxt = pre_wrap ? 4'h0 : pre_cnt_r + 4'h1;
    wire logic [6:0] rate_cnt_nxt = rate_wrap ? 7'h00 : rate_cnt_r + 7'h01;
    wire logic [5:0] bit_cnt_nxt = bit_cnt_r + 6'h01; // Wraps by itself at 64

    // Reference edge detector; resets low, so a reference that is high
    // when reset ends gives one edge at once
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            xref_q_r <= 1'b0;
        end else begin
            xref_q_r <= crystal_ref_clock_i;
        end
    end

    // Prescaler stage
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_cnt_r <= 4'h0;
        end else if (src_en) begin
            pre_cnt_r <= pre_cnt_nxt;
        end
    end

    // Rate stage
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rate_cnt_r <= 7'h00;
        end else if (pre_wrap) begin
            rate_cnt_r <= rate_cnt_nxt;
        end
    end

    // Bit phase, shared by receiver and transmitter
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_cnt_r <= 6'h00;
        end else if (rate_wrap) begin
            bit_cnt_r <= bit_cnt_nxt;
        end
    end

    // Ticks are registered so both leave the block free of glitches
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_tick_r <= 1'b0;
            sample_tick_r <= 1'b0;
        end else begin
            bit_tick_r <= bit_wrap;
            sample_tick_r <= sample_hit;
        end
    end

    assign bit_tick_o = bit_tick_r;
    assign sample_tick_o = sample_tick_r;
endmodule

// File: verif/sdb_core_props.sv
// Port checks for the serial data buffer and baud generator
`timescale 1ns/1ps
module sdb_chk
    import sdb_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic rx_valid_i,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_accept_o,
    input wire logic bit_tick_o,
    input wire logic sample_tick_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // Status read step of the receive handshake
    sequence s_stat_rd;
        reg_rd_i && reg_addr_i == SDB_STAT_OFS;
    endsequence
    chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not idle");
    chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i > SDB_STAT_OFS |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_rx_full_seen: assert property (rx_valid_i ##2 s_stat_rd |=> reg_rdata_o[SDB_STAT_RXF])
        else $error("rx-full not shown");
    chk_tx_push: assert property (reg_wr_i && reg_addr_i == SDB_DATA_OFS && tx_accept_o |=> tx_valid_o)
        else $error("byte not queued");
    chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("queued byte lost");
    chk_bit_gap: assert property (bit_tick_o |=> !bit_tick_o [*8])
        else $error("bit ticks too close");
    chk_sample_gap: assert property (sample_tick_o |=> !sample_tick_o [*3])
        else $error("sample ticks too close");
    chk_reset_quiet: assert property ($rose(rst_b_i) |-> !tx_valid_o && !bit_tick_o)
        else $error("busy after reset");
endmodule

bind sdb_core sdb_chk u_sdb_chk (.*);

// File: verif/sdb_far_end.sv
// Far-side model: shifter taking transmit bytes, receiver handing in bytes
`timescale 1ns/1ps
module sdb_far_end (
    input wire logic core_clk_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic stall_i,
    output logic tx_ready_o = 1'b0,
    output logic rx_valid_o = 1'b0,
    output logic [7:0] rx_data_o = 8'h00
);
    logic [7:0] got[$];
    // Ready follows stall one edge late, as a busy shifter would
    always @(posedge core_clk_i) begin
        tx_ready_o <= !stall_i;
        if (tx_valid_i && tx_ready_o) begin
            got.push_back(tx_data_i);
        end
    end
    // One byte; data turns to its inverse once no longer valid
    task automatic deliver(input logic [7:0] b);
        rx_data_o <= b;
        rx_valid_o <= 1'b1;
        @(posedge core_clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~b;
    endtask
endmodule

// File: verif/sdb_core_bench.sv
// Register-level bench for the serial data buffer and baud generator
`timescale 1ns/1ps
module sdb_core_bench;
    import sdb_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, sel = 1'b0, stall = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, tx_data, rx_data;
    logic rx_valid, tx_valid, tx_ready, accept, bit_tick, smp_tick;
    logic [2:0] xc = 3'h0;
    int miscompares = 0, n_checks = 0, n, i;
    int pd[4] = '{1, 3, 4, 13};
    always #12.5 clk = ~clk;
    // Crystal reference: six-cycle square wave, moved only after core edges
    always @(posedge clk) xc <= (xc == 3'h5) ? 3'h0 : xc + 3'h1;
    sdb_core u_sdb_core (.core_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .baud_clock_source_sel_i(sel),
        .crystal_ref_clock_i(xc > 3'h2), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .tx_valid_o(tx_valid),
        .tx_ready_i(tx_ready), .tx_data_o(tx_data), .tx_accept_o(accept), .bit_tick_o(bit_tick),
        .sample_tick_o(smp_tick));
    sdb_far_end u_sdb_far_end (.core_clk_i(clk), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .stall_i(stall), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Data buffer is only read or written whole, never modified in place
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic creg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        cmp(rdata & m, e);
    endtask
    // Time second to third tick, so a rate change has settled first
    task automatic gap(input logic use_bit, input int want);
        int k;
        k = 0;
        n = 0;
        while (k < 3 && n < 9000) begin
            @(posedge clk);
            #1;
            n++;
            if ((use_bit ? bit_tick : smp_tick) === 1'b1) begin
                k++;
                n = (k < 3) ? 0 : n;
            end
        end
        cmp(n, want);
    endtask
    task automatic finish_test;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        creg(SDB_BAUD_OFS, 8'h37, 8'h00);
        creg(SDB_STAT_OFS, 8'ha0, 8'h80);
        creg(8'h1b, 8'hff, 8'h00);
        for (i = 0; i < 12; i++) begin
            wreg(SDB_BAUD_OFS, (i < 4) ? 8'(i << 4) : 8'(i - 4));
            gap(1'b0, (i < 4) ? 4 * pd[i] : 4 << (i - 4));
        end
        wreg(SDB_BAUD_OFS, 8'h11);
        gap(1'b1, 384);
        sel <= 1'b1;
        wreg(SDB_BAUD_OFS, 8'h00);
        gap(1'b0, 24);
        sel <= 1'b0;
        u_sdb_far_end.deliver(8'h5a);
        creg(SDB_STAT_OFS, 8'h20, 8'h20);
        creg(SDB_DATA_OFS, 8'hff, 8'h5a);
        creg(SDB_STAT_OFS, 8'h20, 8'h00);
        stall <= 1'b1;
        creg(SDB_STAT_OFS, 8'h80, 8'h80);
        wreg(SDB_DATA_OFS, 8'hc3);
        creg(SDB_STAT_OFS, 8'h80, 8'h00);
        creg(SDB_DATA_OFS, 8'hff, 8'h5a);
        for (i = 0; i < 8; i++) begin
            wreg(SDB_DATA_OFS, 8'(i));
        end
        #1;
        cmp(accept, 1'b0);
        stall <= 1'b0;
        for (i = 0; i < 60 && u_sdb_far_end.got.size() < 8; i++) begin
            @(posedge clk);
        end
        cmp(u_sdb_far_end.got.size(), 8);
        foreach (u_sdb_far_end.got[j]) begin
            cmp(u_sdb_far_end.got[j], (j == 0) ? 8'hc3 : 8'(j - 1));
        end
        creg(SDB_STAT_OFS, 8'h80, 8'h80);
        // Second reset: codes clear, received byte survives
        wreg(SDB_BAUD_OFS, 8'h37);
        u_sdb_far_end.deliver(8'ha5);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        creg(SDB_DATA_OFS, 8'hff, 8'ha5);
        creg(SDB_BAUD_OFS, 8'h37, 8'h00);
        creg(SDB_STAT_OFS, 8'ha0, 8'h80);
        finish_test();
    end
    // Watchdog: the sequence needs well under 10k cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule
